// [design/rvp_core.sv]
// Purpose: Reset vector selection, reset state of control bits and priority resolver
// Assumes: Reset causes and requests are synchronous to clk_i
// Notes:   Registers on classic Wishbone, one word each
//
// Functional notes
// - Reset vector chosen by cause; special modes use BFxx addresses.
// - Non-maskable ranking: reset, clock monitor, watchdog, nmi pin, illegal, swi.
// - Default maskable ranking of fifteen sources from external pin to serial system.
// - Priority field lifts one maskable source, others keep their order.
// - Promoted source still obeys global mask and local enable.
// - Vector of each source fixed regardless of promotion.
// - Priority register writable only while global maskable mask set.
// - Priority field resets to 0101, external pin highest.
// - Vector fetched in three cycles; both masks and stop inhibit set.
// - Mapping register resets so RAM at 0000 and registers at 1000.
// - Expanded modes give ports B, C, F to bus; single chip all inputs.
// - Timer count, prescaler cleared; compares FFFF; flags and enables cleared.
// - Capture4/compare5 select cleared; compare5 mode and level cleared.
// - Realtime flag, its enable and rate bits cleared.
// - Pulse accumulator disabled at reset.
// - Watchdog enabled unless disable bit set; shortest rate.
// - Async serial: masked, off, 8-bit, flags per reset state.
// - Synchronous serial peripheral disabled at reset.
// - Converter power-up bit and complete flag cleared.
// - EEPROM programming off; external pin level sensitive.
// - Boot, special and mode-A bits taken from mode inputs at reset release.
// - Stop delay bit set; both clock monitor enables cleared.
// - Code 0101 falls back to external pin like 0110.
`timescale 1ns/100ps
`default_nettype none

module rvp_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Reset causes, held with rst_i
  input  wire logic        cause_cmf_i,
  input  wire logic        cause_wdog_i,
  // Mode inputs
  input  wire logic        mode_select_b_input_i,
  input  wire logic        mode_select_a_input_i,
  input  wire logic        watchdog_disable_bit_i,
  input  wire logic [3:0]  eeprom_position_bits_i,
  // Requests
  input  wire logic        nmi_req_i,
  input  wire logic        ill_req_i,
  input  wire logic        swi_req_i,
  input  wire logic [14:0] mreq_i,
  input  wire logic [14:0] men_i,
  // Core global masks
  input  wire logic        core_i_mask_i,
  input  wire logic        core_x_mask_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core outputs
  output logic             fetch_o,
  output logic      [15:0] reset_vec_o,
  output logic             irq_valid_o,
  output logic      [15:0] irq_vec_o,
  output logic      [2:0]  ccr_init_o,
  output logic             expanded_bus_o,
  output logic             watchdog_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode capture and reset cause

  logic        boot_rom_read_bit_r;
  logic        special_mode_bit_r;
  logic        mode_a_bit_r;
  logic        rst_d_r;
  logic [1:0]  cause_r;
  logic [1:0]  cause_nxt;
  logic        wb_wr;
  logic [3:0]  wadr;

  assign wadr  = wb_adr_i[5:2];
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    rst_d_r <= rst_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_rom_read_bit_r <= 1'b0;
      special_mode_bit_r  <= 1'b0;
      mode_a_bit_r        <= 1'b0;
    end else if (rst_d_r) begin
      boot_rom_read_bit_r <= ~mode_select_b_input_i & ~mode_select_a_input_i;
      special_mode_bit_r  <= ~mode_select_b_input_i;
      mode_a_bit_r        <= mode_select_a_input_i;
    end
  end

  always_comb begin
    if (cause_cmf_i) begin
      cause_nxt = 2'd1;
    end else if (cause_wdog_i) begin
      cause_nxt = 2'd2;
    end else begin
      cause_nxt = 2'd0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_r <= cause_nxt;
    end
  end

  // reset vector by cause and mode
  function automatic logic [15:0] rst_vec(input logic [1:0] c, input logic spc);
    logic [15:0] v;
    v = (c == 2'd1) ? rvp_pkg::VEC_CMF : (c == 2'd2) ? rvp_pkg::VEC_WDOG : rvp_pkg::VEC_POR;
    rst_vec = spc ? (v & rvp_pkg::SPECIAL_MASK) : v;
  endfunction

  assign reset_vec_o = rst_vec(cause_r, special_mode_bit_r);

  ////////////////////////////////////////////////////////////////////////////
  // Fetch sequencer

  rvp_pkg::rvp_state_e state_r;
  logic [1:0]          fcnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= rvp_pkg::RVP_FETCH;
      fcnt_r  <= 2'd0;
    end else begin
      case (state_r)
        rvp_pkg::RVP_FETCH: begin
          fcnt_r <= fcnt_r + 2'd1;
          if (fcnt_r == 2'(rvp_pkg::FETCH_CYC - 1)) begin
            state_r <= rvp_pkg::RVP_RUN;
          end
        end
        rvp_pkg::RVP_RUN: begin
          state_r <= rvp_pkg::RVP_RUN;
        end
        default: begin
          state_r <= rvp_pkg::RVP_FETCH;
        end
      endcase
    end
  end

  assign fetch_o = (state_r == rvp_pkg::RVP_FETCH);
  assign ccr_init_o = 3'b111;

  ////////////////////////////////////////////////////////////////////////////
  // Control bits with reset states

  logic [3:0]  psel_r;
  logic [7:0]  map_init_r;
  logic [7:0]  tmr_ctl_r;   // Prescaler, pin actions, edges and enables
  logic [15:0] tcnt_r;
  logic [15:0] toc_r;
  logic [7:0]  per_r;
  logic [1:0]  wd_rate_r;
  logic [2:0]  opt_r;       // delay, cme, forced_clock_monitor_bit

  // priority field writes gated by mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psel_r <= rvp_pkg::PSEL_RST;
    end else if (wb_wr && wadr == rvp_pkg::ADR_PRIO && core_i_mask_i) begin
      psel_r <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      map_init_r <= rvp_pkg::MAP_INIT_RST;
    end else if (wb_wr && wadr == rvp_pkg::ADR_MAPCFG) begin
      map_init_r <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_ctl_r <= 8'h00;
      tcnt_r    <= rvp_pkg::TCNT_RST;
      toc_r     <= rvp_pkg::TOC_RST;
    end else begin
      tcnt_r <= tcnt_r + 16'h0001;
      if (wb_wr && wadr == rvp_pkg::ADR_TIMER) begin
        tmr_ctl_r <= wb_dat_i[7:0];
      end
      if (wb_wr && wadr == rvp_pkg::ADR_COMPARE && wb_sel_i[1]) begin
        toc_r <= wb_dat_i[15:0];
      end
    end
  end

  // serial, converter, eeprom and pin sense
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_r <= 8'h03;  // Both transmit-empty flags set, all else clear
    end else if (wb_wr && wadr == rvp_pkg::ADR_PERIPH) begin
      per_r <= wb_dat_i[7:0];
    end
  end

  // watchdog rate and clock monitor options
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_rate_r <= 2'b00;
      opt_r     <= 3'b100;
    end else if (wb_wr && wadr == rvp_pkg::ADR_CORE) begin
      wd_rate_r <= wb_dat_i[1:0];
      opt_r     <= wb_dat_i[4:2];
    end
  end

  assign watchdog_en_o  = ~watchdog_disable_bit_i;
  // expanded modes take ports B, C, F
  assign expanded_bus_o = mode_a_bit_r;

  ////////////////////////////////////////////////////////////////////////////
  // Priority resolver

  function automatic logic [3:0] promo(input logic [3:0] p);
    case (p)
      4'h0:    promo = rvp_pkg::S_TOF;
      4'h1:    promo = rvp_pkg::S_PAOV;
      4'h2:    promo = rvp_pkg::S_PAED;
      4'h3:    promo = rvp_pkg::S_SPI;
      4'h4:    promo = rvp_pkg::S_SCI;
      4'h7:    promo = rvp_pkg::S_RTI;
      4'h8:    promo = rvp_pkg::S_IC1;
      4'h9:    promo = rvp_pkg::S_IC2;
      4'ha:    promo = rvp_pkg::S_IC3;
      4'hb:    promo = rvp_pkg::S_OC1;
      4'hc:    promo = rvp_pkg::S_OC2;
      4'hd:    promo = rvp_pkg::S_OC3;
      4'he:    promo = rvp_pkg::S_OC4;
      4'hf:    promo = rvp_pkg::S_IC4;
      default: promo = rvp_pkg::S_IRQ;
    endcase
  endfunction

  logic [14:0] live;
  logic [3:0]  ps;
  logic        m_hit;
  logic [15:0] m_vec;
  logic        nmi_live;

  // masking applies to promoted source too
  assign live     = mreq_i & men_i & {15{~core_i_mask_i}};
  assign ps       = promo(psel_r);
  assign nmi_live = nmi_req_i & ~core_x_mask_i;

  always_comb begin
    m_hit = 1'b0;
    m_vec = rvp_pkg::VEC_NONE;
    for (int i = rvp_pkg::NSRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        m_hit = 1'b1;
        m_vec = rvp_pkg::MVEC[i];
      end
    end
    if (live[ps]) begin
      m_vec = rvp_pkg::MVEC[ps];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_valid_o <= 1'b0;
      irq_vec_o   <= rvp_pkg::VEC_NONE;
    end else if (fetch_o) begin
      irq_valid_o <= 1'b0;
      irq_vec_o   <= rvp_pkg::VEC_NONE;
    end else begin
      irq_valid_o <= nmi_live | ill_req_i | swi_req_i | m_hit;
      irq_vec_o   <= nmi_live  ? rvp_pkg::VEC_NMI :
                     ill_req_i ? rvp_pkg::VEC_ILL :
                     swi_req_i ? rvp_pkg::VEC_SWI : m_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone read and ack

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wadr)
        rvp_pkg::ADR_PRIO:    wb_dat_o <= {24'h0, boot_rom_read_bit_r, special_mode_bit_r,
                                           mode_a_bit_r, 1'b0, psel_r};
        rvp_pkg::ADR_CAUSE:   wb_dat_o <= {30'h0, cause_r};
        rvp_pkg::ADR_VECTOR:  wb_dat_o <= {irq_valid_o, 15'h0, irq_vec_o};
        rvp_pkg::ADR_CORE:    wb_dat_o <= {27'h0, opt_r, wd_rate_r};
        rvp_pkg::ADR_TIMER:   wb_dat_o <= {tcnt_r, 8'h0, tmr_ctl_r};
        rvp_pkg::ADR_PERIPH:  wb_dat_o <= {24'h0, per_r};
        rvp_pkg::ADR_MAPCFG:  wb_dat_o <= {20'h0, eeprom_position_bits_i, map_init_r};
        rvp_pkg::ADR_COMPARE: wb_dat_o <= {16'h0, toc_r};
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_psel_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> psel_r == 4'h5)
    else $error("priority field not 0101 after reset");
  a_psel_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_wr && wadr == 4'h0 && !core_i_mask_i) |=> $stable(psel_r))
    else $error("priority field written while unmasked");
  a_fetch_len: assert property (@(posedge clk_i) $fell(rst_i) |-> fetch_o [*3] ##1 !fetch_o)
    else $error("vector fetch not three cycles");
  a_vec_wdog: assert property (@(posedge clk_i) disable iff (rst_i)
    (cause_r == 2'd2 && !special_mode_bit_r) |-> reset_vec_o == 16'hfffa)
    else $error("watchdog vector wrong");
  a_mask_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (core_i_mask_i && !nmi_req_i && !ill_req_i && !swi_req_i) |=> !irq_valid_o)
    else $error("masked request passed");
  a_promo_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fetch_o && live[ps] && !nmi_live && !ill_req_i && !swi_req_i)
    |=> irq_vec_o == $past(rvp_pkg::MVEC[ps]))
    else $error("promoted source not first");
  a_nmi_first: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fetch_o && nmi_live) |=> irq_vec_o == 16'hfff4)
    else $error("nmi not above other requests");
  a_tmr_reset: assert property (@(posedge clk_i) $fell(rst_i) |->
    toc_r == 16'hffff && tmr_ctl_r == 8'h00 && tcnt_r == 16'h0000)
    else $error("timer reset state wrong");
  a_opt_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> opt_r == 3'b100)
    else $error("clock monitor options reset wrong");

  // Further reset states, cause ranking and fetch quiet time
  a_rate_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> wd_rate_r == 2'b00)
    else $error("watchdog rate not shortest after reset");
  a_map_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> map_init_r == 8'h01)
    else $error("mapping register reset wrong");
  a_per_reset: assert property (@(posedge clk_i) $fell(rst_i) |-> per_r == 8'h03)
    else $error("serial and converter reset state wrong");
  a_cmf_first: assert property (@(posedge clk_i) (rst_i && cause_cmf_i) |=> cause_r == 2'd1)
    else $error("clock monitor cause not ranked first");
  a_vec_special: assert property (@(posedge clk_i) disable iff (rst_i)
    special_mode_bit_r |-> reset_vec_o[14] == 1'b0)
    else $error("special mode vector not in BFxx page");
  a_mode_load: assert property (@(posedge clk_i) (!rst_i && rst_d_r)
    |=> special_mode_bit_r == !$past(mode_select_b_input_i) && mode_a_bit_r == $past(mode_select_a_input_i))
    else $error("mode bits not taken at reset release");
  a_fetch_quiet: assert property (@(posedge clk_i) disable iff (rst_i) fetch_o |=> !irq_valid_o)
    else $error("request presented during vector fetch");
  a_ill_next: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fetch_o && !nmi_live && ill_req_i) |=> irq_vec_o == 16'hfff8)
    else $error("illegal trap not above swi and maskable");

endmodule

`default_nettype wire

// [design/rvp_pkg.sv]
// Purpose: Shared constants for the reset vector and priority block
// Assumes: 16-bit vector addresses, Wishbone register window
// Notes:   Source indices follow the default maskable ranking
package rvp_pkg;

  // Register word addresses (byte address = 4 * index)
  localparam logic [3:0] ADR_PRIO    = 4'h0;
  localparam logic [3:0] ADR_CAUSE   = 4'h1;
  localparam logic [3:0] ADR_VECTOR  = 4'h2;
  localparam logic [3:0] ADR_CORE    = 4'h3;
  localparam logic [3:0] ADR_TIMER   = 4'h4;
  localparam logic [3:0] ADR_PERIPH  = 4'h5;
  localparam logic [3:0] ADR_MAPCFG  = 4'h6;
  localparam logic [3:0] ADR_COMPARE = 4'h7;

  // Reset values
  localparam logic [3:0]  PSEL_RST     = 4'h5;
  localparam logic [3:0]  PSEL_IRQ     = 4'h6;
  localparam logic [7:0]  MAP_INIT_RST = 8'h01;
  localparam logic [15:0] TCNT_RST     = 16'h0000;
  localparam logic [15:0] TOC_RST      = 16'hffff;
  localparam logic [15:0] RAM_TOP      = 16'h03ff;
  localparam logic [15:0] REG_TOP      = 16'h105f;

  // Vectors
  localparam logic [15:0] VEC_POR      = 16'hfffe;
  localparam logic [15:0] VEC_CMF      = 16'hfffc;
  localparam logic [15:0] VEC_WDOG     = 16'hfffa;
  localparam logic [15:0] VEC_NMI      = 16'hfff4;
  localparam logic [15:0] VEC_ILL      = 16'hfff8;
  localparam logic [15:0] VEC_SWI      = 16'hfff6;
  localparam logic [15:0] SPECIAL_MASK = 16'hbfff;
  localparam logic [15:0] VEC_NONE     = 16'h0000;

  // Cycles of vector fetch after reset
  localparam int unsigned FETCH_CYC = 3;

  // Maskable sources in default ranking order, index 0 highest
  localparam int unsigned NSRC = 15;
  localparam logic [3:0] S_IRQ  = 4'd0;
  localparam logic [3:0] S_RTI  = 4'd1;
  localparam logic [3:0] S_IC1  = 4'd2;
  localparam logic [3:0] S_IC2  = 4'd3;
  localparam logic [3:0] S_IC3  = 4'd4;
  localparam logic [3:0] S_OC1  = 4'd5;
  localparam logic [3:0] S_OC2  = 4'd6;
  localparam logic [3:0] S_OC3  = 4'd7;
  localparam logic [3:0] S_OC4  = 4'd8;
  localparam logic [3:0] S_IC4  = 4'd9;
  localparam logic [3:0] S_TOF  = 4'd10;
  localparam logic [3:0] S_PAOV = 4'd11;
  localparam logic [3:0] S_PAED = 4'd12;
  localparam logic [3:0] S_SPI  = 4'd13;
  localparam logic [3:0] S_SCI  = 4'd14;

  // Vector of each maskable source, fixed whatever is promoted
  localparam logic [15:0] MVEC [NSRC] = '{
    16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea,
    16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0,
    16'hffde, 16'hffdc, 16'hffda, 16'hffd8, 16'hffd6};

  typedef enum logic [1:0] {
    RVP_FETCH = 2'b00,
    RVP_RUN   = 2'b01
  } rvp_state_e;

endpackage

// [testbench/rvp_core_model.sv]
// Purpose: Behavioural processor core facing the priority block
// Assumes: Mask requests from the bench take effect one edge later
// Notes:   Masks follow the reset state while the vector is fetched
`timescale 1ns/100ps
`default_nettype none

module rvp_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        fetch_i,
  input  wire logic [2:0]  ccr_init_i,
  input  wire logic        irq_valid_i,
  input  wire logic [15:0] irq_vec_i,
  input  wire logic        i_want_i,
  input  wire logic        x_want_i,
  output logic             i_mask_o,
  output logic             x_mask_o,
  output logic      [15:0] taken_vec_o
);
  ////////////////////////////////////////
  // masks from reset state
  always_ff @(posedge clk_i) begin
    if (rst_i || fetch_i) begin
      x_mask_o <= ccr_init_i[2];
      i_mask_o <= ccr_init_i[1];
    end else begin
      i_mask_o <= i_want_i;
      x_mask_o <= x_want_i;
    end
  end

  // Vector the core would fetch next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      taken_vec_o <= 16'h0000;
    end else if (irq_valid_i) begin
      taken_vec_o <= irq_vec_i;
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the reset vector and priority block
// Assumes: Core model drives the global masks
// Notes:   Random requests from a fixed seed plus corner cases
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i, cause_cmf_i, cause_wdog_i, mode_select_b_input_i, mode_select_a_input_i;
  logic        watchdog_disable_bit_i, nmi_req_i, ill_req_i, swi_req_i, core_i_mask_i;
  logic        core_x_mask_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fetch_o, irq_valid_o;
  logic        expanded_bus_o, watchdog_en_o, i_want, x_want, c, w, mb, ma, nc;
  logic [3:0]  eeprom_position_bits_i, wb_sel_i, psel;
  logic [5:0]  wb_adr_i;
  logic [14:0] mreq_i, men_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] reset_vec_o, irq_vec_o, taken_vec;
  logic [2:0]  ccr_init_o;
  logic [16:0] e;
  integer      seed = 32'h9bcbba61;
  int          err_count = 0;
  int          compares = 0;

  rvp_core i_dut (.clk_i, .rst_i, .cause_cmf_i, .cause_wdog_i, .mode_select_b_input_i,
    .mode_select_a_input_i, .watchdog_disable_bit_i, .eeprom_position_bits_i, .nmi_req_i,
    .ill_req_i, .swi_req_i, .mreq_i, .men_i, .core_i_mask_i, .core_x_mask_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fetch_o,
    .reset_vec_o, .irq_valid_o, .irq_vec_o, .ccr_init_o, .expanded_bus_o, .watchdog_en_o);

  rvp_core_model i_core (.clk_i, .rst_i, .fetch_i(fetch_o), .ccr_init_i(ccr_init_o),
    .irq_valid_i(irq_valid_o), .irq_vec_i(irq_vec_o), .i_want_i(i_want), .x_want_i(x_want),
    .i_mask_o(core_i_mask_i), .x_mask_o(core_x_mask_i), .taken_vec_o(taken_vec));

  // Free-running bus clock
  always #4 clk_i = ~clk_i;

  ////////////////////////////////////////
  // Promoted source index for a priority code
  function automatic logic [3:0] prom_idx(input logic [3:0] p);
    if (p < 4'h5) return p + 4'ha;
    if (p < 4'h7) return 4'h0;
    return p - 4'h6;
  endfunction

  // Expected valid flag and vector
  function automatic logic [16:0] exp_irq(input logic [2:0] nis, input logic xm, im,
                                          input logic [14:0] rq, en, input logic [3:0] p);
    logic [14:0] act;
    act = rq & en & {15{~im}};
    if (nis[2] && !xm) return {1'b1, rvp_pkg::VEC_NMI};
    if (nis[1]) return {1'b1, rvp_pkg::VEC_ILL};
    if (nis[0]) return {1'b1, rvp_pkg::VEC_SWI};
    if (act[prom_idx(p)]) return {1'b1, rvp_pkg::MVEC[prom_idx(p)]};
    for (int k = 0; k < 15; k++) begin
      if (act[k]) return {1'b1, rvp_pkg::MVEC[k]};
    end
    return 17'h00000;
  endfunction

  // Expected reset vector from cause and mode
  function automatic logic [15:0] exp_rvec(input logic ce, we, b);
    logic [15:0] v;
    v = ce ? rvp_pkg::VEC_CMF : (we ? rvp_pkg::VEC_WDOG : rvp_pkg::VEC_POR);
    return b ? v : (v & rvp_pkg::SPECIAL_MASK);
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we_v, input logic [3:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we_v, idx, 2'b00, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    if (wb_ack_o !== 1'b1) chk("wb_ack", 32'h1, 32'h0);
  endtask

  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] m, ex, input string nm);
    wb(1'b0, idx, 32'h0);
    chk(nm, ex, rd & m);
  endtask

  task automatic do_reset(input logic ce, we, b, a, ncp);
    int n;
    n = 0;
    @(posedge clk_i);
    {rst_i, cause_cmf_i, cause_wdog_i, mode_select_b_input_i} <= {1'b1, ce, we, b};
    {mode_select_a_input_i, watchdog_disable_bit_i} <= {a, ncp};
    eeprom_position_bits_i <= 4'($random(seed));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) begin
      #1;
      n += int'(fetch_o === 1'b1);
      @(posedge clk_i);
    end
    chk("fetch_cycles", rvp_pkg::FETCH_CYC, n);
  endtask

  // Masks requested from the core model
  task automatic set_masks(input logic im, input logic xm);
    @(posedge clk_i);
    {i_want, x_want} <= {im, xm};
    repeat (2) @(posedge clk_i);
  endtask

  task automatic irq_step(input logic [2:0] nis, input logic [14:0] rq, en);
    @(posedge clk_i);
    {nmi_req_i, ill_req_i, swi_req_i, mreq_i, men_i} <= {nis, rq, en};
    @(posedge clk_i);
    #1;
    e = exp_irq(nis, x_want, i_want, rq, en, psel);
    chk("irq_valid", 32'(e[16]), 32'(irq_valid_o));
    if (e[16]) chk("irq_vec", 32'(e[15:0]), 32'(irq_vec_o));
    @(posedge clk_i);
    #1;
    if (e[16]) chk("taken_vec", 32'(e[15:0]), 32'(taken_vec));
  endtask

  task automatic stop_test();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Hang guard
  initial begin
    #400000;
    err_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    {rst_i, i_want, x_want, wb_sel_i} = 7'h7f;
    {cause_cmf_i, cause_wdog_i, mode_select_b_input_i, mode_select_a_input_i} = 4'h0;
    {watchdog_disable_bit_i, nmi_req_i, ill_req_i, swi_req_i, wb_cyc_i, wb_stb_i} = 6'h00;
    {wb_we_i, eeprom_position_bits_i, wb_adr_i, mreq_i, men_i, wb_dat_i} = '0;
    psel = 4'h5;
    for (int k = 0; k < 6; k++) begin
      c = (k % 3 == 1);
      w = (k % 3 != 0);
      mb = (k < 3);
      ma = 1'($random(seed));
      nc = 1'($random(seed));
      do_reset(c, w, mb, ma, nc);
      chk("reset_vec", 32'(exp_rvec(c, w, mb)), 32'(reset_vec_o));
      chk("ccr_init", 32'h7, 32'(ccr_init_o));
      chk("watchdog_en", 32'(!nc), 32'(watchdog_en_o));
      chk("expanded_bus", 32'(ma), 32'(expanded_bus_o));
      rd_chk(4'h0, 32'hff, {24'h0, !mb && !ma, !mb, ma, 5'h05}, "prio");
      rd_chk(4'h1, 32'h3, c ? 32'h1 : (w ? 32'h2 : 32'h0), "cause");
      rd_chk(4'h2, 32'hffffffff, 32'h0, "vector_idle");
      rd_chk(4'h3, 32'h1f, 32'h10, "option");
      rd_chk(4'h4, 32'hff, 32'h0, "timer_ctl");
      rd_chk(4'h5, 32'hff, 32'h3, "periph");
      rd_chk(4'h6, 32'hfff, {20'h0, eeprom_position_bits_i, 8'h01}, "map");
      rd_chk(4'h7, 32'hffff, 32'hffff, "compare");
      rd_chk(4'h9, 32'hffffffff, 32'h0, "unmapped");
      // Disturb state so the next reset has work to do
      wb(1'b1, 4'h7, 32'h1234);
      wb(1'b1, 4'h3, 32'h0f);
      $display("test reset %0d done", k);
    end
    do_reset(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    for (int p = 0; p < 16; p++) begin
      set_masks(1'b1, 1'b1);
      wb(1'b1, 4'h0, 32'(p));
      psel = 4'(p);
      rd_chk(4'h0, 32'hf, 32'(p), "psel");
      set_masks(1'b0, 1'b0);
      wb(1'b1, 4'h0, 32'(~p & 15));
      rd_chk(4'h0, 32'hf, 32'(p), "psel_locked");
      irq_step(3'b000, 15'h7fff, 15'h7fff);
      irq_step(3'b000, 15'h7fff, 15'h7fff ^ (15'h1 << prom_idx(psel)));
      for (int j = 0; j < 6; j++) begin
        irq_step(3'($random(seed) & $random(seed)), 15'($random(seed) & $random(seed)),
                 15'($random(seed)));
      end
      set_masks(1'b1, 1'b1);
      irq_step(3'($random(seed)) & 3'b100, 15'h7fff, 15'h7fff);
      $display("test priority %0d done", p);
    end
    stop_test();
  end
endmodule
`default_nettype wire
